// >>> include/dpf_pkg.sv
// constants and types for the periodic response framer
package dpf_pkg;

    // register byte offsets and fields
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_LAYOUT = 4'h4;
    localparam logic [3:0] ADDR_STAT   = 4'h8;
    localparam int CTRL_MUTE = 0;
    localparam int CTRL_FRAG = 1;
    localparam int CTRL_SS   = 2;
    localparam int CTRL_PERIODIC_COLLECTION_MODE = 3;
    localparam logic [3:0] CTRL_RESET   = 4'h8;
    localparam int LAY_FMT_LSB = 4;
    localparam logic [2:0] LAYOUT_RESET = 3'h7;
    localparam int FMT_TAG  = 0;
    localparam int FMT_KAC  = 1;
    localparam int FMT_STAT = 2;
    localparam int STAT_DIAG = 4;
    localparam int STAT_ERRP = 5;

    // status codes of the upper half
    localparam logic [3:0] ST_UOTP  = 4'h8;
    localparam logic [3:0] ST_URW   = 4'h9;
    localparam logic [3:0] ST_FOTP  = 4'ha;
    localparam logic [3:0] ST_TEST  = 4'hb;
    localparam logic [3:0] ST_SUP   = 4'hc;
    localparam logic [3:0] ST_RST   = 4'hd;
    localparam logic [3:0] ST_RES_A = 4'he;
    localparam logic [3:0] ST_RES_B = 4'hf;

    // message and crc shape
    localparam int DATA_W  = 10;
    localparam int MSG_W   = 20;
    localparam int CRC_LEN = 8;
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [3:0] SEED_HI  = 4'h0;
    localparam logic [9:0] ERR_CODE = 10'h200;
    localparam int BIT_DIV = 20;

    // diagnostic response shape
    localparam int DIAG_W = 16;
    localparam logic [3:0] FRAGS_WIDE   = 4'h4;
    localparam logic [3:0] FRAGS_NARROW = 4'h8;

    typedef enum logic [2:0] {CMD_BCAST, CMD_FRAG, CMD_DREAD, CMD_DWRITE, CMD_OTHER} dpf_cmd_e;
    typedef enum logic [1:0] {F_IDLE, F_MSG, F_ZERO, F_CRC} dpf_fstate_e;
endpackage

// >>> rtl/dpf_crc8.sv
// serial 8-bit crc shift register with seed preset
`timescale 1ns/1ns
module dpf_crc8 (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // control
    input  wire logic       load,
    input  wire logic [7:0] seed,
    input  wire logic       shift,
    input  wire logic       din,
    // result
    output logic      [7:0] crc
);
    logic [7:0] crc_q;
    logic [7:0] crc_d;

    // message bits rotate in at the lsb, feedback from the msb
    always_comb begin
        crc_d = crc_q;
        if (load) begin
            crc_d = seed;
        end else if (shift) begin
            crc_d = {crc_q[6:0], din} ^ (crc_q[7] ? dpf_pkg::CRC_POLY : 8'h00);
        end
    end

    // register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            crc_q <= 8'h00;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc = crc_q;
endmodule

// >>> rtl/dpf_framer.sv
// periodic response framer with background diagnostic fragments
`timescale 1ns/1ns
module dpf_framer #(
    parameter int BIT_DIV = dpf_pkg::BIT_DIV
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    // avalon-mm slave
    input  wire logic [3:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    // decoded commands from the bus receiver
    input  wire logic                        cmdStrobe,
    input  wire dpf_pkg::dpf_cmd_e           cmdKind,
    input  wire logic [3:0]                  cmdSlot,
    input  wire logic [7:0]                  cmdAddr,
    input  wire logic [3:0]                  slotTag,
    // device state
    input  wire logic                        userOtpFault,
    input  wire logic                        userRwFault,
    input  wire logic                        factOtpFault,
    input  wire logic                        testActiveFlag,
    input  wire logic                        supplyFault,
    input  wire logic                        supplyTimerDone,
    input  wire logic                        resetOccurredFlag,
    input  wire logic [1:0]                  reservedFault,
    input  wire logic [3:0]                  baseStatus,
    input  wire logic [dpf_pkg::DATA_W-1:0]  sensorData,
    input  wire logic [dpf_pkg::DIAG_W-1:0]  diagRespData,
    // periodic response bit stream
    output logic                             txBit,
    output logic                             txStrobe,
    // diagnostic fragments and register read
    output logic                             diagFragStrobe,
    output logic      [3:0]                  diagFragData,
    output logic      [3:0]                  diagFragSlot,
    output logic                             diagRdReq,
    output logic      [7:0]                  diagRdAddr,
    // mode levels
    output logic                             sampleMode,
    output logic                             diagFragSize
);
    localparam int DW = dpf_pkg::DATA_W;
    localparam int MW = dpf_pkg::MSG_W;

    // lowest priority number first: reserved, reset, supply, test, otp
    function automatic logic [4:0] prioCode(input logic [7:0] f);
        logic [4:0] r;
        r = 5'h00;
        if (f[0])      r = {1'b1, dpf_pkg::ST_RES_A};
        else if (f[1]) r = {1'b1, dpf_pkg::ST_RES_B};
        else if (f[2]) r = {1'b1, dpf_pkg::ST_RST};
        else if (f[3]) r = {1'b1, dpf_pkg::ST_SUP};
        else if (f[4]) r = {1'b1, dpf_pkg::ST_TEST};
        else if (f[5]) r = {1'b1, dpf_pkg::ST_FOTP};
        else if (f[6]) r = {1'b1, dpf_pkg::ST_URW};
        else if (f[7]) r = {1'b1, dpf_pkg::ST_UOTP};
        return r;
    endfunction

    // status selection
    logic [7:0] faults;
    logic [4:0] prio;
    logic [3:0] stCode;
    assign faults = {userOtpFault, userRwFault, factOtpFault, testActiveFlag,
                     supplyFault, resetOccurredFlag, reservedFault[1], reservedFault[0]};
    assign prio   = prioCode(faults);
    assign stCode = prio[4] ? prio[3:0] : baseStatus;

    // ---------------- register slave ----------------
    logic [3:0]  ctrl_q, ctrl_d;
    logic [2:0]  lay_q [16];
    logic [2:0]  lay_d [16];
    logic [3:0]  layTag_q, layTag_d;
    logic        wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic        errPend_q;
    logic        diagAct_q;

    // one wait state: the access completes on the cycle waitrequest is low
    always_comb begin
        ctrl_d   = ctrl_q;
        lay_d    = lay_q;
        layTag_d = layTag_q;
        wait_d   = 1'b1;
        rdata_d  = rdata_q;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            if (avs_read) begin
                case (avs_address)
                    dpf_pkg::ADDR_CTRL:   rdata_d = {28'h0000000, ctrl_q};
                    dpf_pkg::ADDR_LAYOUT: rdata_d = {25'h0, lay_q[layTag_q], layTag_q};
                    dpf_pkg::ADDR_STAT:   rdata_d = {26'h0, errPend_q, diagAct_q, stCode};
                    default:              rdata_d = 32'h00000000;
                endcase
            end
        end
        if (avs_write && !wait_q) begin
            case (avs_address)
                dpf_pkg::ADDR_CTRL: ctrl_d = avs_writedata[3:0];
                dpf_pkg::ADDR_LAYOUT: begin
                    layTag_d = avs_writedata[3:0];
                    lay_d[avs_writedata[3:0]] = avs_writedata[dpf_pkg::LAY_FMT_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q   <= dpf_pkg::CTRL_RESET;
            lay_q    <= '{default: dpf_pkg::LAYOUT_RESET};
            layTag_q <= 4'h0;
            wait_q   <= 1'b1;
            rdata_q  <= 32'h00000000;
        end else begin
            ctrl_q   <= ctrl_d;
            lay_q    <= lay_d;
            layTag_q <= layTag_d;
            wait_q   <= wait_d;
            rdata_q  <= rdata_d;
        end
    end

    // ---------------- periodic framer ----------------
    dpf_pkg::dpf_fstate_e fst_q, fst_d;
    logic [MW-1:0] msg_q, msg_d;
    logic [4:0]    len_q, len_d;
    logic [4:0]    cnt_q, cnt_d;
    logic [7:0]    div_q, div_d;
    logic [1:0]    kac_q [16];
    logic [1:0]    kac_d [16];
    logic          errPend_d;
    logic          txBit_q, txBit_d;
    logic          txStb_q, txStb_d;
    logic          tick, frameGo, errSet, errUse;
    logic          crcLoad, crcShift, crcDin;
    logic [7:0]    crcVal;
    logic [2:0]    fmt;
    logic [MW-1:0] m;
    logic [4:0]    n;

    // bit rate enable; it restarts with each frame; bits are evenly spaced only when BIT_DIV is 9 or more, as the zero feed takes 8 cycles
    assign tick = (div_q == 8'(BIT_DIV - 1));
    // mute while the supply monitor runs: no periodic frame starts, but diagnostic fragments still go out
    assign frameGo = cmdStrobe && ctrl_q[dpf_pkg::CTRL_PERIODIC_COLLECTION_MODE]
                     && (cmdKind == dpf_pkg::CMD_BCAST || cmdKind == dpf_pkg::CMD_FRAG)
                     && !(supplyFault && !supplyTimerDone);
    // sticky request for at least one error-coded data field
    assign errSet = (prio[4] && !supplyFault)
                    || (supplyFault && supplyTimerDone && !ctrl_q[dpf_pkg::CTRL_MUTE]);
    assign errUse = errSet || errPend_q;
    assign fmt    = lay_q[slotTag];

    // frame assembly and serialisation
    always_comb begin
        fst_d     = fst_q;
        msg_d     = msg_q;
        len_d     = len_q;
        cnt_d     = cnt_q;
        div_d     = tick ? 8'h00 : div_q + 8'h01;
        kac_d     = kac_q;
        errPend_d = errPend_q;
        txBit_d   = txBit_q;
        txStb_d   = 1'b0;
        crcLoad   = 1'b0;
        crcShift  = 1'b0;
        crcDin    = 1'b0;
        m         = '0;
        n         = 5'h00;
        case (fst_q)
            dpf_pkg::F_IDLE: begin
                div_d = 8'h00;
                if (frameGo) begin
                    if (fmt[dpf_pkg::FMT_TAG]) begin
                        m = {m[MW-5:0], slotTag};
                        n = n + 5'd4;
                    end
                    if (fmt[dpf_pkg::FMT_KAC]) begin
                        m = {m[MW-3:0], kac_q[slotTag]};
                        n = n + 5'd2;
                    end
                    if (fmt[dpf_pkg::FMT_STAT]) begin
                        m = {m[MW-5:0], stCode};
                        n = n + 5'd4;
                    end
                    m = {m[MW-DW-1:0], (errUse ? dpf_pkg::ERR_CODE : sensorData)};
                    n = n + 5'(DW);
                    msg_d = m << (5'(MW) - n); // left aligned, msb goes first
                    len_d = n;
                    cnt_d = 5'h00;
                    kac_d[slotTag] = kac_q[slotTag] + 2'h1;
                    errPend_d = errSet; // a fresh set survives the clear
                    crcLoad = 1'b1;
                    fst_d = dpf_pkg::F_MSG;
                end else if (errSet) begin
                    errPend_d = 1'b1;
                end
            end
            dpf_pkg::F_MSG: begin
                if (errSet) errPend_d = 1'b1;
                if (tick) begin
                    txBit_d  = msg_q[MW-1];
                    txStb_d  = 1'b1;
                    crcShift = 1'b1;
                    crcDin   = msg_q[MW-1];
                    msg_d    = {msg_q[MW-2:0], 1'b0};
                    cnt_d    = cnt_q + 5'h01;
                    if (cnt_q == len_q - 5'h01) begin
                        cnt_d = 5'h00;
                        fst_d = dpf_pkg::F_ZERO;
                    end
                end
            end
            dpf_pkg::F_ZERO: begin
                // zeros are pushed at core rate so the crc is ready by the next bit
                if (errSet) errPend_d = 1'b1;
                crcShift = 1'b1;
                cnt_d    = cnt_q + 5'h01;
                if (cnt_q == 5'(dpf_pkg::CRC_LEN - 1)) begin
                    cnt_d = 5'h00;
                    fst_d = dpf_pkg::F_CRC;
                end
            end
            dpf_pkg::F_CRC: begin
                if (errSet) errPend_d = 1'b1;
                if (tick) begin
                    txBit_d = crcVal[3'd7 - cnt_q[2:0]];
                    txStb_d = 1'b1;
                    cnt_d   = cnt_q + 5'h01;
                    if (cnt_q == 5'(dpf_pkg::CRC_LEN - 1)) begin
                        cnt_d = 5'h00;
                        fst_d = dpf_pkg::F_IDLE;
                    end
                end
            end
            default: fst_d = dpf_pkg::F_IDLE;
        endcase
    end

    // register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fst_q     <= dpf_pkg::F_IDLE;
            msg_q     <= '0;
            len_q     <= 5'h00;
            cnt_q     <= 5'h00;
            div_q     <= 8'h00;
            kac_q     <= '{default: 2'h0};
            errPend_q <= 1'b0;
            txBit_q   <= 1'b0;
            txStb_q   <= 1'b0;
        end else begin
            fst_q     <= fst_d;
            msg_q     <= msg_d;
            len_q     <= len_d;
            cnt_q     <= cnt_d;
            div_q     <= div_d;
            kac_q     <= kac_d;
            errPend_q <= errPend_d;
            txBit_q   <= txBit_d;
            txStb_q   <= txStb_d;
        end
    end

    dpf_crc8 u_crc (
        .core_clk (core_clk),
        .resetn   (resetn),
        .load     (crcLoad),
        .seed     ({dpf_pkg::SEED_HI, slotTag}),
        .shift    (crcShift),
        .din      (crcDin),
        .crc      (crcVal)
    );

    // ---------------- background diagnostic ----------------
    logic              diagArm_q, diagArm_d;
    logic              diagAct_d;
    logic [3:0]        frag_q, frag_d;
    localparam int DIAG_W_L = dpf_pkg::DIAG_W - 1;
    logic [DIAG_W_L:0] word_q;
    logic [DIAG_W_L:0] word_d, w;
    logic [3:0]        slot_q, slot_d;
    logic              fStb_q, fStb_d;
    logic [3:0]        fDat_q, fDat_d;
    logic              rdReq_q, rdReq_d;
    logic [7:0]        rdAddr_q, rdAddr_d;
    logic              wide;

    assign wide = ctrl_q[dpf_pkg::CTRL_FRAG];

    // fragments go out only on broadcast reads after an armed command
    always_comb begin
        diagArm_d = diagArm_q;
        diagAct_d = diagAct_q;
        frag_d    = frag_q;
        word_d    = word_q;
        slot_d    = slot_q;
        fStb_d    = 1'b0;
        fDat_d    = fDat_q;
        rdReq_d   = 1'b0;
        rdAddr_d  = rdAddr_q;
        w         = word_q;
        if (cmdStrobe) begin
            case (cmdKind)
                dpf_pkg::CMD_DREAD: begin
                    if (ctrl_q[dpf_pkg::CTRL_PERIODIC_COLLECTION_MODE]) begin
                        diagArm_d = 1'b1;
                        diagAct_d = 1'b0;
                        frag_d    = 4'h0;
                        slot_d    = cmdSlot;
                        rdReq_d   = 1'b1;
                        rdAddr_d  = cmdAddr;
                    end
                end
                dpf_pkg::CMD_BCAST: begin
                    if (diagArm_q || diagAct_q) begin
                        if (diagArm_q) w = diagRespData;
                        fStb_d = 1'b1;
                        fDat_d = wide ? w[DIAG_W_L -: 4] : {2'b00, w[DIAG_W_L -: 2]};
                        word_d = wide ? {w[DIAG_W_L-4:0], 4'h0} : {w[DIAG_W_L-2:0], 2'h0};
                        frag_d = frag_q + 4'h1;
                        diagArm_d = 1'b0;
                        diagAct_d = (frag_q + 4'h1) != (wide ? dpf_pkg::FRAGS_WIDE : dpf_pkg::FRAGS_NARROW);
                    end
                end
                // writes are never executed, fragments and others abandon
                default: begin
                    diagArm_d = 1'b0;
                    diagAct_d = 1'b0;
                end
            endcase
        end
    end

    // register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            diagArm_q <= 1'b0;
            diagAct_q <= 1'b0;
            frag_q    <= 4'h0;
            word_q    <= '0;
            slot_q    <= 4'h0;
            fStb_q    <= 1'b0;
            fDat_q    <= 4'h0;
            rdReq_q   <= 1'b0;
            rdAddr_q  <= 8'h00;
        end else begin
            diagArm_q <= diagArm_d;
            diagAct_q <= diagAct_d;
            frag_q    <= frag_d;
            word_q    <= word_d;
            slot_q    <= slot_d;
            fStb_q    <= fStb_d;
            fDat_q    <= fDat_d;
            rdReq_q   <= rdReq_d;
            rdAddr_q  <= rdAddr_d;
        end
    end

    // outputs straight from flops
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign txBit           = txBit_q;
    assign txStrobe        = txStb_q;
    assign diagFragStrobe  = fStb_q;
    assign diagFragData    = fDat_q;
    assign diagFragSlot    = slot_q;
    assign diagRdReq       = rdReq_q;
    assign diagRdAddr      = rdAddr_q;
    assign sampleMode      = ctrl_q[dpf_pkg::CTRL_SS];
    assign diagFragSize    = ctrl_q[dpf_pkg::CTRL_FRAG];

    // checks
    a_uotp_code: assert property (@(posedge core_clk) disable iff (!resetn)
        faults == 8'h80 |-> stCode == 4'h8) else $error("user otp code wrong");
    a_urw_code: assert property (@(posedge core_clk) disable iff (!resetn)
        faults[7:6] == 2'b11 && faults[5:0] == 6'h00 |-> stCode == 4'h9) else $error("rw code wrong");
    a_reserved_wins: assert property (@(posedge core_clk) disable iff (!resetn)
        reservedFault[0] |-> stCode == 4'he) else $error("priority order wrong");
    a_supply_mute: assert property (@(posedge core_clk) disable iff (!resetn)
        supplyFault && !supplyTimerDone && fst_q == dpf_pkg::F_IDLE |=> fst_q == dpf_pkg::F_IDLE)
        else $error("frame sent while muted");
    a_crc_seed: assert property (@(posedge core_clk) disable iff (!resetn)
        fst_q == dpf_pkg::F_IDLE && frameGo |=> crcVal == {4'h0, $past(slotTag)})
        else $error("crc seed wrong");
    a_zero_feed: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(fst_q == dpf_pkg::F_ZERO) |-> (fst_q == dpf_pkg::F_ZERO)[*8] ##1 fst_q == dpf_pkg::F_CRC)
        else $error("zero feed length wrong");
    a_frag_on_bcast: assert property (@(posedge core_clk) disable iff (!resetn)
        fStb_q |-> $past(cmdStrobe) && $past(cmdKind) == dpf_pkg::CMD_BCAST)
        else $error("fragment without broadcast");
    a_diag_abandon: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdStrobe && cmdKind inside {dpf_pkg::CMD_FRAG, dpf_pkg::CMD_DWRITE, dpf_pkg::CMD_OTHER}
        |=> !diagAct_q && !diagArm_q ##1 !fStb_q) else $error("diag not abandoned");
    a_narrow_frag: assert property (@(posedge core_clk) disable iff (!resetn)
        fStb_q && !$past(wide) |-> fDat_q[3:2] == 2'b00) else $error("narrow fragment too wide");
    a_no_write_read: assert property (@(posedge core_clk) disable iff (!resetn)
        cmdStrobe && cmdKind == dpf_pkg::CMD_DWRITE |=> !rdReq_q) else $error("write executed");
endmodule

// >>> verif/dpf_master.sv
// command-side model of the bus master
`timescale 1ns/1ns
module dpf_master (
    // clock
    input  wire logic        core_clk,
    // decoded commands
    output dpf_pkg::dpf_cmd_e cmdKind,
    output logic             cmdStrobe,
    output logic [3:0]       cmdSlot,
    output logic [7:0]       cmdAddr
);
    // idle bus until the first command
    initial begin
        cmdStrobe = 1'b0;
        cmdKind = dpf_pkg::CMD_OTHER;
        cmdSlot = 4'h0;
        cmdAddr = 8'h00;
    end
    // one decoded command per call, strobe high for one cycle
    task automatic send(input dpf_pkg::dpf_cmd_e k, input logic [3:0] s, input logic [7:0] a);
        @(posedge core_clk);
        cmdStrobe <= 1'b1;
        cmdKind <= k;
        cmdSlot <= s;
        cmdAddr <= a;
        @(posedge core_clk);
        cmdStrobe <= 1'b0;
    endtask
endmodule

// >>> verif/tb.sv
// self-checking bench for the periodic response framer
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, supTmr = 1'b1;
    logic [3:0] avs_address = 4'h0, slotTag = 4'h4;
    logic [31:0] avs_writedata = '0, avs_readdata, rmask = '1;
    logic [7:0] flt = 8'h00, cmdAddr, diagRdAddr;
    logic [9:0] sensorData = 10'h1ea;
    logic [15:0] diagRespData = '0;
    logic avs_waitrequest, txBit, txStrobe, diagFragStrobe, diagRdReq, sampleMode, diagFragSize, cmdStrobe;
    logic [3:0] diagFragData, diagFragSlot, cmdSlot;
    dpf_pkg::dpf_cmd_e cmdKind;
    int fail_count = 0, n_compared = 0, cyc = 0, nb = 0;
    logic [27:0] sh;
    logic [31:0] qF[$], qD[$], qA[$], qR[$];

    dpf_master dpf_master_i (.core_clk(core_clk), .cmdKind(cmdKind), .cmdStrobe(cmdStrobe), .cmdSlot(cmdSlot),
        .cmdAddr(cmdAddr));
    dpf_framer #(.BIT_DIV(2)) dpf_framer_i (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmdStrobe(cmdStrobe), .cmdKind(cmdKind), .cmdSlot(cmdSlot),
        .cmdAddr(cmdAddr), .slotTag(slotTag), .userOtpFault(flt[0]), .userRwFault(flt[1]), .factOtpFault(flt[2]),
        .testActiveFlag(flt[3]), .supplyFault(flt[4]), .supplyTimerDone(supTmr), .resetOccurredFlag(flt[5]),
        .reservedFault(flt[7:6]), .baseStatus(4'h0), .sensorData(sensorData), .diagRespData(diagRespData),
        .txBit(txBit), .txStrobe(txStrobe), .diagFragStrobe(diagFragStrobe), .diagFragData(diagFragData),
        .diagFragSlot(diagFragSlot), .diagRdReq(diagRdReq), .diagRdAddr(diagRdAddr), .sampleMode(sampleMode),
        .diagFragSize(diagFragSize));

    // 20 MHz clock
    initial forever #25 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // reference crc: seed in low bits, message msb first, then eight zeros
    function automatic logic [7:0] crc(input logic [19:0] m);
        logic [7:0] r;
        r = {4'h0, slotTag};
        for (int i = 27; i >= 0; i--) r = {r[6:0], i > 7 ? m[i-8] : 1'b0} ^ (r[7] ? 8'h2f : 8'h00);
        return r;
    endfunction

    // avalon master; for a read, d is the expected data
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        if (!w) qR.push_back(d);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    // watcher: each result takes the oldest note; frames outside a test go unnoted
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            close_out();
        end
        if (avs_read && !avs_waitrequest) check(avs_readdata & rmask, qR.pop_front());
        if (diagRdReq) check(diagRdAddr, qA.size() ? qA.pop_front() : 'x);
        if (diagFragStrobe) check({diagFragSlot, diagFragData}, qD.size() ? qD.pop_front() : 'x);
        if (txStrobe) begin
            sh = {sh[26:0], txBit};
            nb++;
        end
        if (nb == 28) begin
            nb = 0;
            if (qF.size()) check(sh, qF.pop_front());
        end
    end

    initial begin
        logic [15:0] d;
        logic [3:0] s;
        logic [7:0] a;
        void'($urandom(32'h33593ecf));
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        bus(0, dpf_pkg::ADDR_CTRL, 32'h8);
        bus(0, dpf_pkg::ADDR_LAYOUT, 32'h70);
        bus(1, dpf_pkg::ADDR_LAYOUT, 32'h35);
        bus(0, dpf_pkg::ADDR_LAYOUT, 32'h35);
        bus(1, 4'hc, '1);
        bus(0, 4'hc, 32'h0);
        bus(1, dpf_pkg::ADDR_CTRL, 32'hc);
        check(sampleMode, 1);
        qF.push_back({4'h4, 2'h0, 4'h0, 10'h1ea, 8'h5f});
        dpf_master_i.send(dpf_pkg::CMD_BCAST, 4'h0, 8'h00);
        while (qF.size()) @(posedge core_clk);
        flt <= 8'h01;
        sensorData <= 10'($urandom);
        qF.push_back({4'h4, 2'h1, 4'h8, 10'h200, crc({4'h4, 2'h1, 4'h8, 10'h200})});
        dpf_master_i.send(dpf_pkg::CMD_BCAST, 4'h0, 8'h00);
        while (qF.size()) @(posedge core_clk);
        // supply fault: silent while the monitor runs, then an error-coded frame
        flt <= 8'h10;
        supTmr <= 1'b0;
        dpf_master_i.send(dpf_pkg::CMD_BCAST, 4'h0, 8'h00);
        repeat (10) @(posedge core_clk);
        check(nb, 0);
        supTmr <= 1'b1;
        qF.push_back({4'h4, 2'h2, 4'hc, 10'h200, crc({4'h4, 2'h2, 4'hc, 10'h200})});
        dpf_master_i.send(dpf_pkg::CMD_BCAST, 4'h0, 8'h00);
        while (qF.size()) @(posedge core_clk);
        // stack faults from least to most severe
        rmask = 32'hf;
        for (int i = 0; i < 7; i++) begin
            flt <= 8'((2 << i) - 1);
            @(posedge core_clk);
            bus(0, dpf_pkg::ADDR_STAT, 32'(4'h8 + i));
        end
        flt <= 8'h00;
        rmask = '1;
        // both fragment sizes, plus abandon by each other kind
        for (int j = 0; j < 5; j++) begin
            if (j < 2) bus(1, dpf_pkg::ADDR_CTRL, 32'(8 + 2 * j));
            if (j < 2) check(diagFragSize, 32'(j));
            if (j < 2) check(sampleMode, 32'h0);
            d = 16'($urandom);
            s = 4'($urandom);
            a = 8'($urandom);
            diagRespData <= d;
            qA.push_back(a);
            dpf_master_i.send(dpf_pkg::CMD_DREAD, s, a);
            for (int k = 0; k < (j == 0 ? 8 : 4); k++) begin
                if (j == 0) qD.push_back({s, 2'b00, d[15-2*k -: 2]});
                else if (j == 1 || k == 0) qD.push_back({s, d[15-4*k -: 4]});
                if (j > 1 && k == 1) dpf_master_i.send(dpf_pkg::dpf_cmd_e'(j == 2 ? 1 : j), s, a);
                dpf_master_i.send(dpf_pkg::CMD_BCAST, s, 8'h00);
                diagRespData <= 16'($urandom);
                repeat (3) @(posedge core_clk);
            end
            dpf_master_i.send(dpf_pkg::CMD_BCAST, s, 8'h00);
            while (qD.size()) @(posedge core_clk);
        end
        repeat (100) @(posedge core_clk);
        close_out();
    end
endmodule
